// *** cpu_decode_pkg.sv ***
`default_nettype none
package cpu_decode_pkg;

   // Instruction groups handled by the decoder.
   typedef enum logic [4:0] {
      OTHER_OP = 5'b00000,
      MOVE_OP = 5'b00001,
      CODE_MEMORY_READ_OP = 5'b00010,
      EXTERNAL_DATA_TRANSFER_OP = 5'b00011,
      EXCHANGE_OP = 5'b00100,
      NIBBLE_EXCHANGE_OP = 5'b00101,
      PUSH_OP = 5'b00110,
      POP_OP = 5'b00111,
      LONG_JUMP_OP = 5'b01000,
      SHORT_JUMP_OP = 5'b01001,
      ABSOLUTE_JUMP_OP = 5'b01010,
      INDIRECT_JUMP_OP = 5'b01011,
      BRANCH_ACC_ZERO = 5'b01100,
      BRANCH_ACC_NONZERO = 5'b01101,
      BRANCH_CARRY_SET = 5'b01110,
      BRANCH_CARRY_CLEAR = 5'b01111,
      BRANCH_BIT_SET = 5'b10000,
      BRANCH_BIT_CLEAR = 5'b10001,
      BRANCH_BIT_SET_AND_CLEAR = 5'b10010,
      COMPARE_BRANCH_UNEQUAL = 5'b10011,
      DECREMENT_BRANCH_NONZERO = 5'b10100,
      BIT_CLEAR_OP = 5'b10101,
      BIT_SET_OP = 5'b10110,
      COMPLEMENT_OP = 5'b10111,
      NO_OP = 5'b11000
   } op_class_e;

   // Operand sources and destinations.
   typedef enum logic [3:0] {
      LOC_NONE = 4'b0000,
      LOC_ACC = 4'b0001,
      LOC_WREG = 4'b0010,
      LOC_DIRECT = 4'b0011,
      LOC_INDIRECT = 4'b0100,
      LOC_IMM = 4'b0101,
      LOC_DATA_PTR = 4'b0110,
      LOC_CODE_DATA_POINTER = 4'b0111,
      LOC_CODE_PC = 4'b1000,
      LOC_XDATA_8 = 4'b1001,
      LOC_XDATA_16 = 4'b1010,
      LOC_STACK = 4'b1011,
      LOC_CARRY = 4'b1100,
      LOC_BIT = 4'b1101,
      LOC_PC = 4'b1110
   } loc_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_OPERAND = 2'b01,
      ST_EXEC = 2'b10
   } seq_e;

   typedef struct packed {
      op_class_e cls;
      loc_e src;
      loc_e dst;
      logic [1:0] bytes;
      logic [2:0] cycles;
      logic known;
   } decode_s;

   localparam logic [1:0] LEN_1 = 2'h1;
   localparam logic [1:0] LEN_2 = 2'h2;
   localparam logic [1:0] LEN_3 = 2'h3;
   localparam logic [2:0] CYC_1 = 3'h1;
   localparam logic [2:0] CYC_2 = 3'h2;
   localparam logic [2:0] CYC_3 = 3'h3;
   localparam logic [2:0] CYC_4 = 3'h4;
   localparam logic [2:0] CYC_5 = 3'h5;
   localparam int WREG_IDX_MSB = 2;
   localparam int PTR_IDX_BIT = 0;

endpackage
`default_nettype wire

// *** cpu_move_branch_bit_decoder.sv ***
`timescale 1ns/100ps
`default_nettype none
module cpu_move_branch_bit_decoder (
   input wire logic clk,
   input wire logic rst,
   input wire logic fetch_valid,
   input wire logic [7:0] fetch_byte,
   input wire logic program_write_select,
   output logic fetch_ready,
   output logic busy,
   output logic instr_done,
   output logic decode_known,
   output cpu_decode_pkg::op_class_e op_class,
   output cpu_decode_pkg::loc_e op_src,
   output cpu_decode_pkg::loc_e op_dst,
   output logic [1:0] op_bytes,
   output logic [2:0] op_cycles,
   output logic [2:0] exec_cycle,
   output logic [2:0] wreg_idx,
   output logic ptr_idx,
   output logic [7:0] first_operand,
   output logic [7:0] second_operand,
   output logic code_space_select,
   output logic [15:0] data_pointer
);
   import cpu_decode_pkg::*;

   typedef struct packed {
      seq_e seq;
      logic fetch_ready;
      logic busy;
      logic done;
      decode_s dec;
      logic [2:0] wreg_idx;
      logic ptr_idx;
      logic [7:0] first_operand;
      logic [7:0] second_operand;
      logic [1:0] bytes_left;
      logic [2:0] cyc_cnt;
      logic code_space;
      logic [15:0] data_pointer;
      logic [3:0] hlp_elapsed;
      logic hlp_stalled;
   } state_s;

   state_s cur;
   state_s next_state;
   logic accept;

   function automatic decode_s mk(
      input op_class_e c,
      input loc_e s,
      input loc_e t,
      input logic [1:0] b,
      input logic [2:0] n
   );
      decode_s d;
      d.cls = c;
      d.src = s;
      d.dst = t;
      d.bytes = b;
      d.cycles = n;
      d.known = 1'b1;
      return d;
   endfunction

   // Opcodes outside these groups are reported as unknown, one byte and
   // one cycle, so the fetch path never hangs on them.
   function automatic decode_s decode(input logic [7:0] op);
      decode_s d;
      d = mk(OTHER_OP, LOC_NONE, LOC_NONE, LEN_1, CYC_1);
      d.known = 1'b0;
      unique casez (op)
         8'b1110_1???: d = mk(MOVE_OP, LOC_WREG, LOC_ACC, LEN_1, CYC_1);
         8'hE5: d = mk(MOVE_OP, LOC_DIRECT, LOC_ACC, LEN_2, CYC_2);
         8'b1110_011?: d = mk(MOVE_OP, LOC_INDIRECT, LOC_ACC, LEN_1, CYC_2);
         8'h74: d = mk(MOVE_OP, LOC_IMM, LOC_ACC, LEN_2, CYC_2);
         8'b0111_1???: d = mk(MOVE_OP, LOC_IMM, LOC_WREG, LEN_2, CYC_2);
         8'b1111_1???: d = mk(MOVE_OP, LOC_ACC, LOC_WREG, LEN_1, CYC_2);
         8'b1010_1???: d = mk(MOVE_OP, LOC_DIRECT, LOC_WREG, LEN_2, CYC_4);
         8'hF5: d = mk(MOVE_OP, LOC_ACC, LOC_DIRECT, LEN_2, CYC_3);
         8'b1000_1???: d = mk(MOVE_OP, LOC_WREG, LOC_DIRECT, LEN_2, CYC_3);
         8'h85: d = mk(MOVE_OP, LOC_DIRECT, LOC_DIRECT, LEN_3, CYC_4);
         8'b1000_011?: d = mk(MOVE_OP, LOC_INDIRECT, LOC_DIRECT, LEN_2, CYC_4);
         8'h75: d = mk(MOVE_OP, LOC_IMM, LOC_DIRECT, LEN_3, CYC_3);
         8'b1111_011?: d = mk(MOVE_OP, LOC_ACC, LOC_INDIRECT, LEN_1, CYC_3);
         8'b1010_011?: d = mk(MOVE_OP, LOC_DIRECT, LOC_INDIRECT, LEN_2, CYC_5);
         8'b0111_011?: d = mk(MOVE_OP, LOC_IMM, LOC_INDIRECT, LEN_2, CYC_3);
         8'h90: d = mk(MOVE_OP, LOC_IMM, LOC_DATA_PTR, LEN_3, CYC_3);
         8'h93: d = mk(CODE_MEMORY_READ_OP, LOC_CODE_DATA_POINTER, LOC_ACC, LEN_1,
                       CYC_3);
         8'h83: d = mk(CODE_MEMORY_READ_OP, LOC_CODE_PC, LOC_ACC, LEN_1,
                       CYC_3);
         8'b1110_001?: d = mk(EXTERNAL_DATA_TRANSFER_OP, LOC_XDATA_8, LOC_ACC,
                              LEN_1, CYC_4);
         8'hE0: d = mk(EXTERNAL_DATA_TRANSFER_OP, LOC_XDATA_16, LOC_ACC,
                       LEN_1, CYC_4);
         8'b1111_001?: d = mk(EXTERNAL_DATA_TRANSFER_OP, LOC_ACC, LOC_XDATA_8,
                              LEN_1, CYC_5);
         8'hF0: d = mk(EXTERNAL_DATA_TRANSFER_OP, LOC_ACC, LOC_XDATA_16,
                       LEN_1, CYC_5);
         8'hC0: d = mk(PUSH_OP, LOC_DIRECT, LOC_STACK, LEN_2, CYC_4);
         8'hD0: d = mk(POP_OP, LOC_STACK, LOC_DIRECT, LEN_2, CYC_3);
         8'b1100_1???: d = mk(EXCHANGE_OP, LOC_WREG, LOC_ACC, LEN_1, CYC_2);
         8'hC5: d = mk(EXCHANGE_OP, LOC_DIRECT, LOC_ACC, LEN_2, CYC_3);
         8'b1100_011?: d = mk(EXCHANGE_OP, LOC_INDIRECT, LOC_ACC, LEN_1, CYC_3);
         8'b1101_011?: d = mk(NIBBLE_EXCHANGE_OP, LOC_INDIRECT, LOC_ACC, LEN_1,
                              CYC_3);
         8'h02: d = mk(LONG_JUMP_OP, LOC_IMM, LOC_PC, LEN_3, CYC_4);
         8'h80: d = mk(SHORT_JUMP_OP, LOC_IMM, LOC_PC, LEN_2, CYC_3);
         8'h73: d = mk(INDIRECT_JUMP_OP, LOC_DATA_PTR, LOC_PC, LEN_1, CYC_2);
         8'b???0_0001: d = mk(ABSOLUTE_JUMP_OP, LOC_IMM, LOC_PC, LEN_2, CYC_3);
         8'h60: d = mk(BRANCH_ACC_ZERO, LOC_ACC, LOC_PC, LEN_2, CYC_3);
         8'h70: d = mk(BRANCH_ACC_NONZERO, LOC_ACC, LOC_PC, LEN_2, CYC_3);
         8'h40: d = mk(BRANCH_CARRY_SET, LOC_CARRY, LOC_PC, LEN_2, CYC_3);
         8'h50: d = mk(BRANCH_CARRY_CLEAR, LOC_CARRY, LOC_PC, LEN_2, CYC_3);
         8'h20: d = mk(BRANCH_BIT_SET, LOC_BIT, LOC_PC, LEN_3, CYC_4);
         8'h30: d = mk(BRANCH_BIT_CLEAR, LOC_BIT, LOC_PC, LEN_3, CYC_4);
         8'h10: d = mk(BRANCH_BIT_SET_AND_CLEAR, LOC_BIT, LOC_PC, LEN_3,
                       CYC_4);
         8'hB5: d = mk(COMPARE_BRANCH_UNEQUAL, LOC_DIRECT, LOC_ACC, LEN_3,
                       CYC_4);
         8'hB4: d = mk(COMPARE_BRANCH_UNEQUAL, LOC_IMM, LOC_ACC, LEN_3,
                       CYC_4);
         8'b1011_1???: d = mk(COMPARE_BRANCH_UNEQUAL, LOC_IMM, LOC_WREG, LEN_3,
                              CYC_4);
         8'b1011_011?: d = mk(COMPARE_BRANCH_UNEQUAL, LOC_IMM, LOC_INDIRECT,
                              LEN_3, CYC_4);
         8'b1101_1???: d = mk(DECREMENT_BRANCH_NONZERO, LOC_WREG, LOC_PC,
                              LEN_2, CYC_3);
         8'hD5: d = mk(DECREMENT_BRANCH_NONZERO, LOC_DIRECT, LOC_PC, LEN_3,
                       CYC_4);
         8'hC3: d = mk(BIT_CLEAR_OP, LOC_NONE, LOC_CARRY, LEN_1, CYC_1);
         8'hD3: d = mk(BIT_SET_OP, LOC_NONE, LOC_CARRY, LEN_1, CYC_1);
         8'hB3: d = mk(COMPLEMENT_OP, LOC_CARRY, LOC_CARRY, LEN_1, CYC_1);
         8'hC2: d = mk(BIT_CLEAR_OP, LOC_NONE, LOC_BIT, LEN_2, CYC_3);
         8'hD2: d = mk(BIT_SET_OP, LOC_NONE, LOC_BIT, LEN_2, CYC_3);
         8'hB2: d = mk(COMPLEMENT_OP, LOC_BIT, LOC_BIT, LEN_2, CYC_3);
         8'h00: d = mk(NO_OP, LOC_NONE, LOC_NONE, LEN_1, CYC_1);
         default: d.known = 1'b0;
      endcase
      return d;
   endfunction

   assign accept = (cur.seq == ST_IDLE) && cur.fetch_ready && fetch_valid;

   always_comb begin
      next_state = cur;
      next_state.done = 1'b0;
      unique case (cur.seq)
         ST_IDLE: begin
            if (accept) begin
               next_state.dec = decode(fetch_byte);
               next_state.wreg_idx = fetch_byte[WREG_IDX_MSB:0];
               next_state.ptr_idx = fetch_byte[PTR_IDX_BIT];
               next_state.first_operand = '0;
               next_state.second_operand = '0;
               next_state.bytes_left = 2'(next_state.dec.bytes - LEN_1);
               next_state.cyc_cnt = CYC_1;
               next_state.hlp_elapsed = 4'h1;
               next_state.hlp_stalled = 1'b0;
               // The select bit is sampled once per transfer so that a
               // change in mid-instruction cannot split its action.
               if (next_state.dec.cls == EXTERNAL_DATA_TRANSFER_OP) begin
                  next_state.code_space = program_write_select;
               end else begin
                  next_state.code_space = 1'b0;
               end
               if (next_state.bytes_left != 2'h0) begin
                  next_state.seq = ST_OPERAND;
               end else if (next_state.dec.cycles == CYC_1) begin
                  next_state.done = 1'b1;
               end else begin
                  next_state.seq = ST_EXEC;
               end
            end
         end
         ST_OPERAND: begin
            next_state.hlp_elapsed = 4'(cur.hlp_elapsed + 4'h1);
            if (fetch_valid) begin
               if (cur.bytes_left == 2'(cur.dec.bytes - LEN_1)) begin
                  next_state.first_operand = fetch_byte;
               end else begin
                  next_state.second_operand = fetch_byte;
               end
               next_state.bytes_left = 2'(cur.bytes_left - LEN_1);
               next_state.cyc_cnt = 3'(cur.cyc_cnt + CYC_1);
               if (next_state.bytes_left == 2'h0) begin
                  if (next_state.cyc_cnt == cur.dec.cycles) begin
                     next_state.seq = ST_IDLE;
                     next_state.done = 1'b1;
                  end else begin
                     next_state.seq = ST_EXEC;
                  end
               end
            end else begin
               // A late operand byte stretches the instruction.
               next_state.hlp_stalled = 1'b1;
            end
         end
         ST_EXEC: begin
            next_state.hlp_elapsed = 4'(cur.hlp_elapsed + 4'h1);
            next_state.cyc_cnt = 3'(cur.cyc_cnt + CYC_1);
            if (next_state.cyc_cnt == cur.dec.cycles) begin
               next_state.seq = ST_IDLE;
               next_state.done = 1'b1;
            end
         end
         default: next_state.seq = ST_IDLE;
      endcase
      // High byte comes first in the instruction stream.
      if (next_state.done && next_state.dec.dst == LOC_DATA_PTR) begin
         next_state.data_pointer = {next_state.first_operand,
                                    next_state.second_operand};
      end
      next_state.fetch_ready = (next_state.seq != ST_EXEC);
      next_state.busy = (next_state.seq != ST_IDLE);
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cur <= '0;
      end else begin
         cur <= next_state;
      end
   end

   assign fetch_ready = cur.fetch_ready;
   assign busy = cur.busy;
   assign instr_done = cur.done;
   assign decode_known = cur.dec.known;
   assign op_class = cur.dec.cls;
   assign op_src = cur.dec.src;
   assign op_dst = cur.dec.dst;
   assign op_bytes = cur.dec.bytes;
   assign op_cycles = cur.dec.cycles;
   assign exec_cycle = cur.cyc_cnt;
   assign wreg_idx = cur.wreg_idx;
   assign ptr_idx = cur.ptr_idx;
   assign first_operand = cur.first_operand;
   assign second_operand = cur.second_operand;
   assign code_space_select = cur.code_space;
   assign data_pointer = cur.data_pointer;

   a_reg_to_acc: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:3] == 5'b11101 |=>
      instr_done && op_cycles == CYC_1 && op_src == LOC_WREG)
      else $error("register to accumulator not one cycle");

   a_direct_acc_load: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte == 8'hE5 |=>
      op_bytes == LEN_2 && op_cycles == CYC_2 && op_src == LOC_DIRECT)
      else $error("direct accumulator load decoded wrongly");

   a_imm_reg_index: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:3] == 5'b01111 |=>
      op_dst == LOC_WREG && op_bytes == LEN_2 &&
      wreg_idx == $past(fetch_byte[2:0]))
      else $error("immediate register load decoded wrongly");

   a_acc_to_reg_time: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:3] == 5'b11111 |=>
      !instr_done ##1 instr_done)
      else $error("accumulator to register not two cycles");

   a_ptr_index: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:1] == 7'b1111011 |=>
      ptr_idx == $past(fetch_byte[0]) && op_dst == LOC_INDIRECT)
      else $error("pointer index not from opcode bit");

   a_data_pointer_load: assert property (@(posedge clk) disable iff (rst)
      instr_done && op_dst == LOC_DATA_PTR |->
      data_pointer == {first_operand, second_operand})
      else $error("data pointer not loaded from operands");

   a_select_capture: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:5] == 3'b111 && fetch_byte[3:2] == 2'b00 &&
      fetch_byte[1:0] != 2'b01 |=>
      code_space_select == $past(program_write_select))
      else $error("write select not captured for external transfer");

   a_xdata_write_time: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte == 8'hF0 |=>
      (!instr_done && !fetch_ready) [*4] ##1 instr_done)
      else $error("external write not five cycles");

   a_direct_copy: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte == 8'h85 |=>
      op_bytes == LEN_3 && op_cycles == CYC_4 && op_dst == LOC_DIRECT)
      else $error("direct to direct copy decoded wrongly");

   a_stack_push: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte == 8'hC0 |=>
      op_bytes == LEN_2 && op_cycles == CYC_4 && op_dst == LOC_STACK)
      else $error("stack push decoded wrongly");

   a_carry_ops: assert property (@(posedge clk) disable iff (rst)
      accept && (fetch_byte == 8'hC3 || fetch_byte == 8'hD3 ||
      fetch_byte == 8'hB3) |=> instr_done && op_dst == LOC_CARRY)
      else $error("carry operation not one cycle");

   a_compare_reg: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:3] == 5'b10111 |=>
      op_class == COMPARE_BRANCH_UNEQUAL && op_bytes == LEN_3 &&
      op_cycles == CYC_4)
      else $error("register compare branch decoded wrongly");

   a_bit_branch: assert property (@(posedge clk) disable iff (rst)
      accept && fetch_byte[7:6] == 2'b00 && fetch_byte[3:0] == 4'h0 &&
      fetch_byte[5:4] != 2'b00 |=>
      op_bytes == LEN_3 && op_cycles == CYC_4 && op_src == LOC_BIT)
      else $error("bit branch decoded wrongly");

   a_exec_length: assert property (@(posedge clk) disable iff (rst)
      instr_done && !cur.hlp_stalled |->
      cur.hlp_elapsed == {1'b0, op_cycles})
      else $error("instruction length in cycles wrong");

endmodule
`default_nettype wire

// *** prog_mem_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
   input wire logic clk,
   input wire logic fetch_ready,
   input wire logic stall,
   output logic fetch_valid,
   output logic [7:0] fetch_byte
);
   logic [7:0] mem [0:15];
   logic [3:0] addr;
   logic [3:0] limit;
   logic taken;
   initial begin
      addr = 4'h0;
      limit = 4'h0;
      taken = 1'b0;
      fetch_valid = 1'b0;
      fetch_byte = 8'hA5;
   end
   always @(posedge clk) begin
      taken <= fetch_ready && fetch_valid;
   end
   // An idle byte lane toggles so a stale byte can never pass for fresh data.
   always @(negedge clk) begin
      if (taken) begin
         addr = addr + 4'h1;
      end
      fetch_valid = !stall && (addr < limit);
      fetch_byte = fetch_valid ? mem[addr] : ~fetch_byte;
   end
endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   import cpu_decode_pkg::*;
   typedef struct packed {
      logic [7:0] op;
      logic [1:0] nb;
      logic [2:0] nc;
      op_class_e cls;
   } row_s;
   logic clk, rst, fetch_valid, program_write_select, stall;
   logic [7:0] fetch_byte, first_operand, second_operand;
   logic fetch_ready, busy, instr_done, decode_known, ptr_idx;
   logic code_space_select;
   op_class_e op_class;
   loc_e op_src, op_dst;
   logic [1:0] op_bytes;
   logic [2:0] op_cycles, exec_cycle, wreg_idx;
   logic [15:0] data_pointer;
   int miscompares, n_checks, k;
   row_s rows [0:44];

   cpu_move_branch_bit_decoder uut (.clk(clk), .rst(rst),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte),
      .program_write_select(program_write_select),
      .fetch_ready(fetch_ready), .busy(busy), .instr_done(instr_done),
      .decode_known(decode_known), .op_class(op_class), .op_src(op_src),
      .op_dst(op_dst), .op_bytes(op_bytes), .op_cycles(op_cycles),
      .exec_cycle(exec_cycle), .wreg_idx(wreg_idx), .ptr_idx(ptr_idx),
      .first_operand(first_operand), .second_operand(second_operand),
      .code_space_select(code_space_select), .data_pointer(data_pointer));

   prog_mem_model pm (.clk(clk), .fetch_ready(fetch_ready), .stall(stall),
      .fetch_valid(fetch_valid), .fetch_byte(fetch_byte));

   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   task report_and_stop;
      $display("checks %0d mismatches %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task chk(input logic ok, input string msg);
      n_checks++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("MISMATCH at %0t: %s", $time, msg);
      end
   endtask

   task load(input logic [7:0] b0, b1, b2, input logic [3:0] n);
      @(negedge clk);
      #1;
      pm.mem[0] = b0;
      pm.mem[1] = b1;
      pm.mem[2] = b2;
      pm.addr = 4'h0;
      pm.limit = n;
   endtask

   // Counts cycles from the opcode-accept edge to the done pulse.
   task run(input int stall_n, output int cyc);
      int i;
      i = 0;
      cyc = 0;
      do begin
         @(negedge clk);
         #5;
         i++;
      end while (i < 20 && !(fetch_ready === 1'b1 && fetch_valid === 1'b1
                 && busy === 1'b0));
      stall = (stall_n > 0);
      do begin
         @(posedge clk);
         #5;
         cyc++;
         if (cyc == stall_n) begin
            stall = 1'b0;
         end
      end while (cyc < 20 && instr_done !== 1'b1);
      if (i == 20 || cyc == 20) begin
         miscompares++;
         $display("MISMATCH at %0t: wait ran out", $time);
         report_and_stop();
      end
   endtask

   initial begin
      rst = 1'b1;
      program_write_select = 1'b0;
      stall = 1'b0;
      miscompares = 0;
      n_checks = 0;
      rows = '{
         '{8'hE9,2'h1,3'h1,MOVE_OP}, '{8'hE5,2'h2,3'h2,MOVE_OP},
         '{8'hE7,2'h1,3'h2,MOVE_OP}, '{8'h74,2'h2,3'h2,MOVE_OP},
         '{8'h7B,2'h2,3'h2,MOVE_OP}, '{8'hFC,2'h1,3'h2,MOVE_OP},
         '{8'hAA,2'h2,3'h4,MOVE_OP}, '{8'hF5,2'h2,3'h3,MOVE_OP},
         '{8'h8D,2'h2,3'h3,MOVE_OP}, '{8'h85,2'h3,3'h4,MOVE_OP},
         '{8'h87,2'h2,3'h4,MOVE_OP}, '{8'h75,2'h3,3'h3,MOVE_OP},
         '{8'hF7,2'h1,3'h3,MOVE_OP}, '{8'hA6,2'h2,3'h5,MOVE_OP},
         '{8'h77,2'h2,3'h3,MOVE_OP}, '{8'h90,2'h3,3'h3,MOVE_OP},
         '{8'h93,2'h1,3'h3,CODE_MEMORY_READ_OP},
         '{8'h83,2'h1,3'h3,CODE_MEMORY_READ_OP},
         '{8'hE3,2'h1,3'h4,EXTERNAL_DATA_TRANSFER_OP},
         '{8'hE0,2'h1,3'h4,EXTERNAL_DATA_TRANSFER_OP},
         '{8'hF2,2'h1,3'h5,EXTERNAL_DATA_TRANSFER_OP},
         '{8'hF0,2'h1,3'h5,EXTERNAL_DATA_TRANSFER_OP},
         '{8'hC0,2'h2,3'h4,PUSH_OP}, '{8'hD0,2'h2,3'h3,POP_OP},
         '{8'hCE,2'h1,3'h2,EXCHANGE_OP},
         '{8'hD7,2'h1,3'h3,NIBBLE_EXCHANGE_OP},
         '{8'h02,2'h3,3'h4,LONG_JUMP_OP},
         '{8'h80,2'h2,3'h3,SHORT_JUMP_OP},
         '{8'h73,2'h1,3'h2,INDIRECT_JUMP_OP},
         '{8'h60,2'h2,3'h3,BRANCH_ACC_ZERO},
         '{8'h70,2'h2,3'h3,BRANCH_ACC_NONZERO},
         '{8'h40,2'h2,3'h3,BRANCH_CARRY_SET},
         '{8'h50,2'h2,3'h3,BRANCH_CARRY_CLEAR},
         '{8'h20,2'h3,3'h4,BRANCH_BIT_SET},
         '{8'h30,2'h3,3'h4,BRANCH_BIT_CLEAR},
         '{8'h10,2'h3,3'h4,BRANCH_BIT_SET_AND_CLEAR},
         '{8'hB5,2'h3,3'h4,COMPARE_BRANCH_UNEQUAL},
         '{8'hB4,2'h3,3'h4,COMPARE_BRANCH_UNEQUAL},
         '{8'hBE,2'h3,3'h4,COMPARE_BRANCH_UNEQUAL},
         '{8'hC3,2'h1,3'h1,BIT_CLEAR_OP}, '{8'hD3,2'h1,3'h1,BIT_SET_OP},
         '{8'hB3,2'h1,3'h1,COMPLEMENT_OP},
         '{8'hC2,2'h2,3'h3,BIT_CLEAR_OP}, '{8'hD2,2'h2,3'h3,BIT_SET_OP},
         '{8'hB2,2'h2,3'h3,COMPLEMENT_OP}};
      repeat (10) @(negedge clk);
      chk(fetch_ready === 1'b0 && busy === 1'b0 && instr_done === 1'b0
          && op_class === OTHER_OP && data_pointer === 16'h0000, "reset");
      rst = 1'b0;
      for (int r = 0; r < 45; r++) begin
         load(rows[r].op, 8'h5A, 8'hC3, {2'h0, rows[r].nb});
         run(0, k);
         chk(k == int'(rows[r].nc), "cycle count");
         chk(op_bytes === rows[r].nb && op_cycles === rows[r].nc, "len");
         chk(op_class === rows[r].cls && decode_known === 1'b1, "cls");
         chk(wreg_idx === rows[r].op[2:0] && ptr_idx === rows[r].op[0], "idx");
         chk(exec_cycle === rows[r].nc, "exec cycle at done");
         $display("row %0d opcode %h done", r, rows[r].op);
      end
      load(8'h90, 8'h12, 8'h34, 4'h3);
      run(0, k);
      chk(data_pointer === 16'h1234 && k == 3, "data pointer");
      chk(first_operand === 8'h12 && second_operand === 8'h34, "order");
      chk(op_src === LOC_IMM && op_dst === LOC_DATA_PTR, "data_pointer locs");
      $display("data pointer test done");
      program_write_select = 1'b1;
      load(8'hE2, 8'h00, 8'h00, 4'h1);
      run(0, k);
      chk(code_space_select === 1'b1, "select captured high");
      load(8'h74, 8'h00, 8'h00, 4'h2);
      run(0, k);
      chk(code_space_select === 1'b0, "select on other op");
      program_write_select = 1'b0;
      load(8'hF3, 8'h00, 8'h00, 4'h1);
      run(0, k);
      chk(code_space_select === 1'b0 && ptr_idx === 1'b1, "select low");
      $display("select test done");
      // A stalled operand byte stretches the five-cycle instruction to six cycles.
      load(8'hA6, 8'h5A, 8'h00, 4'h2);
      run(2, k);
      chk(k == 6 && first_operand === 8'h5A, "stalled operand");
      chk(op_src === LOC_DIRECT && op_dst === LOC_INDIRECT, "locs");
      $display("stall test done");
      load(8'hA5, 8'h00, 8'h00, 4'h1);
      run(0, k);
      chk(decode_known === 1'b0 && op_bytes === 2'h1 && k == 1, "unknown");
      $display("unknown opcode test done");
      load(8'hE8, 8'hF9, 8'h00, 4'h2);
      run(0, k);
      chk(k == 1 && wreg_idx === 3'h0, "first of pair");
      @(posedge clk);
      #5;
      chk(instr_done === 1'b0 && busy === 1'b1, "second busy");
      @(posedge clk);
      #5;
      chk(instr_done === 1'b1 && wreg_idx === 3'h1, "second done");
      $display("back to back test done");
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      chk(fetch_ready === 1'b0 && busy === 1'b0, "second reset");
      rst = 1'b0;
      load(8'hD3, 8'h00, 8'h00, 4'h1);
      run(0, k);
      chk(op_class === BIT_SET_OP && k == 1, "after reset");
      $display("second reset test done");
      report_and_stop();
   end
endmodule
`default_nettype wire
